// ---- hw/spfr_fpu_core.v ----
// spfr_fpu_core.v: single-precision multiply with operand decode,
// flush-to-zero, nan/inf handling, rounding and result flags, plus
// an axi4-lite slave for the config bit and the flag registers.
// assumes operands come from the core register file on clk, and that
// swException feeds an edge-sensitive interrupt controller input.
`timescale 1ns/1ps
`default_nettype none
`include "spfr_consts.vh"

// Behaviour
// - operand is sign, 8-bit exponent, 23-bit fraction
// - normal values get hidden one, 24-bit significand
// - codes 1..254 normal, exponent minus 127
// - all-ones exponent, nonzero fraction is nan
// - all-ones exponent, zero fraction is signed infinity
// - zero exponent and fraction is signed zero
// - no inexact flag or exception ever
// - nan input: invalid, quiet nan, xor sign
// - denormal inputs flushed, no underflow exception
// - denormal or underflowed result zero, underflow exception
// - config bit clear: round nearest, ties even
// - config bit set: truncate beyond 23 bits
// - overflow, underflow, invalid raise software exception
// - zero and negative flags per fp instruction
// - overflow flag per instruction, sticky copy set on each overflow
// - sticky invalid set on nan input, kept
// - sticky underflow on denormal result or input
module spfr_fpu_core (
  input  wire        clk,
  input  wire        rst_n,
  // operation issue from the register file
  input  wire        opValid,
  input  wire [31:0] opA,
  input  wire [31:0] opB,
  // result back to the register file
  output reg         resValid_ff,
  output reg  [31:0] resData_ff,
  // edge toward the interrupt controller
  output reg         swException_ff,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // decoded operand fields, index 0 is opA, index 1 is opB
  wire [1:0]  dSign;    // sign bits
  wire [15:0] dExp;     // exponent codes
  wire [47:0] dSig;     // flushed significands
  wire [1:0]  dNan;     // nan class
  wire [1:0]  dInf;     // infinity class
  wire [1:0]  dZero;    // zero or flushed denormal
  wire [1:0]  dDenorm;  // denormal input seen
  wire [63:0] opBoth;   // both operands packed

  assign opBoth = {opB, opA};

  // one decoder per operand
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gDecode
      spfr_operand_decode uDec (
        .opnd     (opBoth[gi*32 +: 32]),
        .sign     (dSign[gi]),
        .expCode  (dExp[gi*8 +: 8]),
        .sig      (dSig[gi*24 +: 24]),
        .isNan    (dNan[gi]),
        .isInf    (dInf[gi]),
        .isZero   (dZero[gi]),
        .isDenorm (dDenorm[gi])
      );
    end
  endgenerate

  // software-visible state
  reg        cfgTrunc_ff;  // rounding mode bit
  reg  [5:0] flags_ff;     // zero, neg, ovf, sticky ovf/inv/unf

  // datapath intermediates
  wire       resSign;      // xor of input signs
  wire [47:0] prod;        // 24x24 significand product
  wire [9:0] expSum;       // biased exponent before normalise
  wire [9:0] expNorm;      // after normalise shift
  wire [22:0] mantRaw;     // kept fraction bits
  wire       guardBit;     // first dropped bit
  wire       stickyBit;    // or of the remaining dropped bits
  wire       roundUp;      // increment decision
  wire [23:0] mantInc;     // fraction plus carry out
  wire [9:0] expRound;     // exponent after rounding carry
  wire       anyNan;       // nan on an input
  wire       zeroTimesInf; // invalid without nan input
  wire       anyInf;       // infinity on an input
  wire       anyZero;      // zero on an input
  wire       expOver;      // unbiased exponent above 127
  wire       expUnder;     // result below smallest normal

  // result sign is xor of input signs
  assign resSign = dSign[0] ^ dSign[1];

  assign prod = dSig[23:0] * dSig[47:24];

  // biased sum minus one bias keeps a single bias
  assign expSum  = {2'b00, dExp[7:0]} + {2'b00, dExp[15:8]} - `SPFR_EXP_BIAS;
  assign expNorm = expSum + {9'h000, prod[47]};

  // product in [1,4): pick the window after the leading one
  assign mantRaw   = prod[47] ? prod[46:24] : prod[45:23];
  assign guardBit  = prod[47] ? prod[23] : prod[22];
  assign stickyBit = prod[47] ? (|prod[22:0]) : (|prod[21:0]);

  // nearest, ties to even lsb; truncate adds nothing
  assign roundUp = ~cfgTrunc_ff & guardBit & (stickyBit | mantRaw[0]);
  // dropped bits raise no flag of their own
  assign mantInc = {1'b0, mantRaw} + {23'h000000, roundUp};
  // carry out of the fraction bumps the exponent, fraction wraps to 0
  assign expRound = expNorm + {9'h000, mantInc[23]};

  assign anyNan       = |dNan;
  assign anyInf       = |dInf;
  assign anyZero      = |dZero;
  assign zeroTimesInf = anyInf & anyZero;

  // unbiased above 127 means biased code 255 or more
  assign expOver  = ~expRound[9] & (expRound[8:0] >= 9'h0ff);
  // biased code zero or negative cannot be held as normal
  assign expUnder = expRound[9] | (expRound == 10'h000);

  // next values of the result stage
  reg [31:0] nxt_res;       // result word
  reg        nxt_ovf;       // overflow this operation
  reg        nxt_unf;       // underflowed result
  reg        nxt_inv;       // invalid operation

  // result selection, priority: nan, inf*zero, inf, zero, range
  always @* begin
    nxt_res = {resSign, expRound[7:0], mantInc[22:0]};
    nxt_ovf = 1'b0;
    nxt_unf = 1'b0;
    nxt_inv = 1'b0;
    if (anyNan) begin
      // quiet nan with xor sign, invalid
      nxt_res = {resSign, `SPFR_EXP_ALL_ONES, `SPFR_QNAN_FRAC};
      nxt_inv = 1'b1;
    end else if (zeroTimesInf) begin
      // zero times infinity has no value either
      nxt_res = {resSign, `SPFR_EXP_ALL_ONES, `SPFR_QNAN_FRAC};
      nxt_inv = 1'b1;
    end else if (anyInf) begin
      nxt_res = {resSign, `SPFR_EXP_ALL_ONES, 23'h000000};
    end else if (anyZero) begin
      // signed zero; flushed input raises nothing here
      nxt_res = {resSign, 31'h00000000};
    end else if (expOver) begin
      // overflow saturates to signed infinity
      nxt_res = {resSign, `SPFR_EXP_ALL_ONES, 23'h000000};
      nxt_ovf = 1'b1;
    end else if (expUnder) begin
      // tiny result flushed to signed zero
      nxt_res = {resSign, 31'h00000000};
      nxt_unf = 1'b1;
    end
  end

  // sticky clear strobes from the bus, built further down
  wire [2:0] stickyClr;    // w1c on sovf, sinv, sunf
  wire       resultZero;   // result exponent and fraction zero

  assign resultZero = (nxt_res[30:0] == 31'h00000000);

  // next flag vector: set always wins over a same-cycle clear
  reg  [5:0] nxt_flags;
  always @* begin
    nxt_flags = flags_ff;
    nxt_flags[`SPFR_ST_SOVF_BIT] = flags_ff[`SPFR_ST_SOVF_BIT] & ~stickyClr[0];
    nxt_flags[`SPFR_ST_SINV_BIT] = flags_ff[`SPFR_ST_SINV_BIT] & ~stickyClr[1];
    nxt_flags[`SPFR_ST_SUNF_BIT] = flags_ff[`SPFR_ST_SUNF_BIT] & ~stickyClr[2];
    if (opValid) begin
      // zero and negative follow the result word
      nxt_flags[`SPFR_ST_ZERO_BIT] = resultZero;
      nxt_flags[`SPFR_ST_NEG_BIT]  = nxt_res[`SPFR_SIGN_BIT];
      // overflow flag set or cleared each operation
      nxt_flags[`SPFR_ST_OVF_BIT]  = nxt_ovf;
      if (nxt_ovf) begin
        nxt_flags[`SPFR_ST_SOVF_BIT] = 1'b1;
      end
      // sticky invalid on a nan input only
      if (anyNan) begin
        nxt_flags[`SPFR_ST_SINV_BIT] = 1'b1;
      end
      // sticky underflow on tiny result or denormal input
      if (nxt_unf | (|dDenorm)) begin
        nxt_flags[`SPFR_ST_SUNF_BIT] = 1'b1;
      end
    end
  end

  // result stage, one cycle after issue
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resValid_ff    <= 1'b0;
      resData_ff     <= 32'h00000000;
      swException_ff <= 1'b0;
      flags_ff       <= `SPFR_FLAGS_RST;
    end else begin
      resValid_ff <= opValid;
      flags_ff    <= nxt_flags;
      swException_ff <= opValid & (nxt_ovf | nxt_unf | nxt_inv);
      // non-fp cycles leave the last result standing
      if (opValid) begin
        resData_ff <= nxt_res;
      end
    end
  end

  // axi4-lite write side: address and data latched in either order
  reg        awHeld_ff;    // write address captured
  reg        wHeld_ff;     // write data captured
  reg  [3:0] awAddr_ff;    // captured write address
  reg [31:0] wData_ff;     // captured write data
  reg  [3:0] wStrb_ff;     // captured byte enables
  wire       doWrite;      // both halves present, response free

  // ready only while the slot is empty and no response is pending
  assign s_axi_awready = ~awHeld_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_ff & ~s_axi_bvalid;
  assign doWrite       = awHeld_ff & wHeld_ff;

  // map an offset to a known register
  function mapped;
    input [3:0] ofs;
    begin
      mapped = (ofs == `SPFR_CONFIG_OFS) | (ofs == `SPFR_STATUS_OFS) |
               (ofs == `SPFR_RESULT_OFS);
    end
  endfunction

  // w1c strobes for the sticky flags, low byte lane only
  assign stickyClr = (doWrite && awAddr_ff == `SPFR_STATUS_OFS && wStrb_ff[0]) ?
                     wData_ff[`SPFR_ST_SUNF_BIT:`SPFR_ST_SOVF_BIT] : 3'h0;

  // write channel capture and response
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_ff    <= 1'b0;
      wHeld_ff     <= 1'b0;
      awAddr_ff    <= 4'h0;
      wData_ff     <= 32'h00000000;
      wStrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPFR_RESP_OKAY;
      cfgTrunc_ff  <= `SPFR_CONFIG_RST;
    end else begin
      // address channel handshake
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= {s_axi_awaddr[3:2], 2'b00};
      end
      // data channel handshake
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      // both halves in: commit and answer
      if (doWrite) begin
        awHeld_ff    <= 1'b0;
        wHeld_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_ff) ? `SPFR_RESP_OKAY : `SPFR_RESP_SLVERR;
        // new mode applies to later issues only
        if (awAddr_ff == `SPFR_CONFIG_OFS && wStrb_ff[0]) begin
          cfgTrunc_ff <= wData_ff[`SPFR_CFG_TRUNC_BIT];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read side: one read at a time, answer next cycle
  assign s_axi_arready = ~s_axi_rvalid;

  // read data mux, reserved bits read zero
  reg [31:0] nxt_rdata;
  always @* begin
    case ({s_axi_araddr[3:2], 2'b00})
      `SPFR_CONFIG_OFS: nxt_rdata = {31'h00000000, cfgTrunc_ff};
      `SPFR_STATUS_OFS: nxt_rdata = {26'h0000000, flags_ff};
      `SPFR_RESULT_OFS: nxt_rdata = resData_ff;
      default:          nxt_rdata = 32'h00000000;
    endcase
  end

  // read channel handshake
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SPFR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= nxt_rdata;
        s_axi_rresp  <= mapped({s_axi_araddr[3:2], 2'b00}) ?
                        `SPFR_RESP_OKAY : `SPFR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // spfr_fpu_core

`default_nettype wire

// ---- hw/spfr_operand_decode.v ----
// spfr_operand_decode.v: splits one 32-bit operand into fields,
// classifies it and flushes denormals to a zero significand.
// assumes a purely combinational use inside spfr_fpu_core.
`timescale 1ns/1ps
`default_nettype none
`include "spfr_consts.vh"

module spfr_operand_decode (
  input  wire [31:0] opnd,
  output wire        sign,
  output wire [7:0]  expCode,
  output wire [23:0] sig,
  output wire        isNan,
  output wire        isInf,
  output wire        isZero,
  output wire        isDenorm
);

  wire [7:0]  expField;  // raw exponent
  wire [22:0] fracField; // raw fraction
  wire        expOnes;   // all-ones exponent
  wire        expNone;   // all-zero exponent
  wire        fracNz;    // nonzero fraction

  assign sign      = opnd[`SPFR_SIGN_BIT];
  assign expField  = opnd[`SPFR_EXP_HI:`SPFR_EXP_LO];
  assign fracField = opnd[`SPFR_FRAC_HI:`SPFR_FRAC_LO];
  assign expOnes   = (expField == `SPFR_EXP_ALL_ONES);
  assign expNone   = (expField == `SPFR_EXP_ZERO);
  assign fracNz    = |fracField;

  assign isNan    = expOnes & fracNz;
  assign isInf    = expOnes & ~fracNz;
  assign isZero   = expNone;
  assign isDenorm = expNone & fracNz;
  assign expCode  = expField;

  // hidden one prepended; denormal flushed to zero
  assign sig = expNone ? 24'h000000 : {1'b1, fracField};

endmodule // spfr_operand_decode

`default_nettype wire

// ---- include/spfr_consts.vh ----
// spfr_consts.vh: offsets, field positions, reset values and timing
// counts shared by the single-precision format and rounding unit.
// assumes inclusion by bare name from the design files under hw/.
`ifndef SPFR_CONSTS_VH
`define SPFR_CONSTS_VH

// operand field layout
`define SPFR_SIGN_BIT      31
`define SPFR_EXP_HI        30
`define SPFR_EXP_LO        23
`define SPFR_FRAC_HI       22
`define SPFR_FRAC_LO       0
`define SPFR_EXP_BIAS      10'h07f
`define SPFR_EXP_ALL_ONES  8'hff
`define SPFR_EXP_ZERO      8'h00
`define SPFR_QNAN_FRAC     23'h400000

// register byte offsets on the axi4-lite bus
`define SPFR_CONFIG_OFS    4'h0
`define SPFR_STATUS_OFS    4'h4
`define SPFR_RESULT_OFS    4'h8

// config field positions and reset value
`define SPFR_CFG_TRUNC_BIT 0
`define SPFR_CONFIG_RST    1'h0

// status field positions
`define SPFR_ST_ZERO_BIT   0
`define SPFR_ST_NEG_BIT    1
`define SPFR_ST_OVF_BIT    2
`define SPFR_ST_SOVF_BIT   3
`define SPFR_ST_SINV_BIT   4
`define SPFR_ST_SUNF_BIT   5
`define SPFR_FLAGS_RST     6'h00

// axi response codes
`define SPFR_RESP_OKAY     2'h0
`define SPFR_RESP_SLVERR   2'h2

// cycles from operation issue to result strobe
`define SPFR_LATENCY       1

`endif

// ---- sim/spfr_fpu_core_monitor.sv ----
// spfr_fpu_core_monitor.sv: concurrent checks on the fpu core ports.
// assumes it is bound onto spfr_fpu_core, one clock domain on clk.
`timescale 1ns/1ps
`default_nettype none
module spfr_fpu_core_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        opValid,
  input wire logic [31:0] opA,
  input wire logic [31:0] opB,
  input wire logic        resValid_ff,
  input wire logic [31:0] resData_ff,
  input wire logic        swException_ff,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  // operand class helpers on the raw fields
  function automatic logic isNanF(input logic [31:0] v);
    return v[30:23] == 8'hff && v[22:0] != 23'h0;
  endfunction
  function automatic logic isInfF(input logic [31:0] v);
    return v[30:23] == 8'hff && v[22:0] == 23'h0;
  endfunction
  function automatic logic isNormF(input logic [31:0] v);
    return v[30:23] != 8'h00 && v[30:23] != 8'hff;
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_res_latency: assert property (opValid |=> resValid_ff)
    else $error("result strobe missing after issue");
  chk_res_cause: assert property (resValid_ff |-> $past(opValid))
    else $error("result strobe without issue");
  chk_exc_with_res: assert property (swException_ff |-> resValid_ff)
    else $error("exception outside a result cycle");
  chk_nan_quiet: assert property (opValid && (isNanF(opA) || isNanF(opB)) |=>
    resData_ff == {$past(opA[31] ^ opB[31]), 8'hff, 23'h400000} && swException_ff)
    else $error("nan input gave wrong result");
  chk_inf_finite: assert property (opValid && isInfF(opA) && isNormF(opB) |=>
    resData_ff == {$past(opA[31] ^ opB[31]), 8'hff, 23'h0} && !swException_ff)
    else $error("infinity times finite wrong");
  chk_denorm_flush: assert property (opValid && opA[30:23] == 8'h00 && isNormF(opB) |=>
    resData_ff == {$past(opA[31] ^ opB[31]), 31'h0} && !swException_ff)
    else $error("flushed operand gave wrong result");
  chk_zero_inf: assert property (opValid && opA[30:0] == 31'h0 && isInfF(opB) |=>
    swException_ff && resData_ff[30:22] == 9'h1ff)
    else $error("zero times infinity not invalid");
  chk_res_holds: assert property (!opValid |=> $stable(resData_ff))
    else $error("result word moved without issue");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // main scenarios reached
  cover property (opValid && isNanF(opA));
  cover property (swException_ff);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // spfr_fpu_core_monitor
`default_nettype wire

// ---- sim/spfr_regfile_model.sv ----
// spfr_regfile_model.sv: register-file and interrupt side of the core.
// assumes the core answers exactly one cycle after the issue edge.
`timescale 1ns/1ps
`default_nettype none
module spfr_regfile_model (
  input  wire logic        clk,
  output var  logic        opValid,
  output var  logic [31:0] opA,
  output var  logic [31:0] opB,
  input  wire logic        resValid_ff,
  input  wire logic [31:0] resData_ff,
  input  wire logic        swException_ff
);
  int excCount = 0; // pulses seen, like an edge interrupt input
  initial begin
    opValid = 1'b0;
    opA = 32'h0;
    opB = 32'h0;
  end
  // each pulse is one handler start
  always @(posedge clk) begin
    if (swException_ff === 1'b1) excCount <= excCount + 1;
  end
  // operands inverted after issue so a stale value never passes
  task automatic issue(input logic [31:0] a, input logic [31:0] b,
                       output logic [31:0] res, output logic [1:0] st);
    @(posedge clk);
    opValid <= 1'b1;
    opA <= a;
    opB <= b;
    @(posedge clk);
    opValid <= 1'b0;
    opA <= ~a;
    opB <= ~b;
    @(posedge clk);
    res = resData_ff;
    st = {resValid_ff, swException_ff};
  endtask
endmodule // spfr_regfile_model
`default_nettype wire

// ---- sim/test_single_precision_fpu_format_rounding.sv ----
// test_single_precision_fpu_format_rounding.sv: bench for spfr_fpu_core.
// assumes the register map of spfr_consts.vh and a 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "spfr_consts.vh"
module test_single_precision_fpu_format_rounding;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  wire         opValid;
  wire  [31:0] opA;
  wire  [31:0] opB;
  wire         resValid_ff;
  wire  [31:0] resData_ff;
  wire         swException_ff;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  wire         s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  wire         s_axi_wready;
  wire  [1:0]  s_axi_bresp;
  wire         s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic        s_axi_arvalid = 1'b0;
  wire         s_axi_arready;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_rresp;
  wire         s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  int          n_mismatch = 0;
  int          checks = 0;
  localparam logic [1:0] OK = `SPFR_RESP_OKAY;
  localparam logic [3:0] ST = `SPFR_STATUS_OFS;
  spfr_fpu_core spfr_fpu_core_i (.clk, .rst_n, .opValid, .opA, .opB, .resValid_ff,
    .resData_ff, .swException_ff, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  spfr_regfile_model spfr_regfile_model_i (.clk, .opValid, .opA, .opB, .resValid_ff,
    .resData_ff, .swException_ff);
  always #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // both halves offered together, each dropped once taken
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp,
                          input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    check({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, rsp});
  endtask
  task automatic axiRead(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, d);
    check({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, rsp});
  endtask
  // one multiply, result word and exception bit judged together
  task automatic op(input logic [31:0] a, input logic [31:0] b, input logic [31:0] r,
                    input logic exc);
    logic [31:0] res;
    logic [1:0]  st;
    spfr_regfile_model_i.issue(a, b, res, st);
    check(res, r);
    check({30'h0, st}, {30'h0, 1'b1, exc});
  endtask
  task automatic tRegs();
    axiRead(`SPFR_CONFIG_OFS, 32'h0, OK);
    axiRead(ST, 32'h0, OK);
    axiRead(`SPFR_RESULT_OFS, 32'h0, OK);
    axiRead(4'hc, 32'h0, `SPFR_RESP_SLVERR);
    axiWrite(4'hc, 32'hffffffff, `SPFR_RESP_SLVERR);
    // lane 0 disabled: mapped write answers okay but changes nothing
    axiWrite(`SPFR_CONFIG_OFS, 32'h1, OK, 4'he);
    axiRead(`SPFR_CONFIG_OFS, 32'h0, OK);
  endtask
  task automatic tFormat();
    op(32'h3f800000, 32'h3fc00000, 32'h3fc00000, 1'b0);
    axiRead(ST, 32'h0, OK);
    op(32'h80000000, 32'h3f800000, 32'h80000000, 1'b0);
    axiRead(ST, 32'h03, OK);
    axiRead(`SPFR_RESULT_OFS, 32'h80000000, OK);
  endtask
  task automatic tNan();
    op(32'h7f800001, 32'h3f800000, 32'h7fc00000, 1'b1);
    op(32'h7fc00000, 32'hbf800000, 32'hffc00000, 1'b1);
    axiRead(ST, 32'h12, OK);
    op(32'h3f800000, 32'h3f800000, 32'h3f800000, 1'b0);
    axiRead(ST, 32'h10, OK);
    axiWrite(ST, 32'h10, OK);
    op(32'h7f800000, 32'hbf800000, 32'hff800000, 1'b0);
    op(32'h00000000, 32'h7f800000, 32'h7fc00000, 1'b1);
    axiRead(ST, 32'h0, OK);
  endtask
  task automatic tRange();
    op(32'h7f000000, 32'h7f000000, 32'h7f800000, 1'b1);
    axiRead(ST, 32'h0c, OK);
    op(32'h3f800000, 32'h3f800000, 32'h3f800000, 1'b0);
    axiRead(ST, 32'h08, OK);
    axiWrite(ST, 32'h08, OK);
    op(32'h00000001, 32'h3f800000, 32'h00000000, 1'b0);
    axiRead(ST, 32'h21, OK);
    op(32'h00800000, 32'h3f000000, 32'h00000000, 1'b1);
    axiWrite(ST, 32'h20, OK);
    axiRead(ST, 32'h01, OK);
  endtask
  // ties both ways, then truncation toggled between operations
  task automatic tRound();
    op(32'h3f800001, 32'h3fc00000, 32'h3fc00002, 1'b0);
    op(32'h3f800003, 32'h3fc00000, 32'h3fc00004, 1'b0);
    axiRead(ST, 32'h0, OK);
    axiWrite(`SPFR_CONFIG_OFS, 32'h1, OK);
    axiRead(`SPFR_CONFIG_OFS, 32'h1, OK);
    op(32'h3f800001, 32'h3fc00000, 32'h3fc00001, 1'b0);
    axiWrite(`SPFR_CONFIG_OFS, 32'h0, OK);
    op(32'h3f800001, 32'h3fc00000, 32'h3fc00002, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tRegs();
    tFormat();
    tNan();
    tRange();
    tRound();
    check(spfr_regfile_model_i.excCount, 32'd5);
    final_report();
  end
  // watchdog: tests need well under a thousand cycles
  initial begin
    #80000;
    n_mismatch++;
    final_report();
  end
endmodule // test_single_precision_fpu_format_rounding
bind spfr_fpu_core spfr_fpu_core_monitor spfr_fpu_core_monitor_i (.clk, .rst_n, .opValid,
  .opA, .opB, .resValid_ff, .resData_ff, .swException_ff, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire
